// ### hdl/astc_pkg.sv
// Purpose: shared constants and types of the async serial transceiver core
// Assumes: 32-bit AHB-Lite register bus, one clock clk_i
// Notes:   register offsets are word indices (haddr bits 11:2); reserved bits read zero
//
// What this block does
// - send start, data LSB first, parity, stops
// - receiver checks overrun, parity, framing, break; stores flags
// - divisor is 16-bit integer plus 6-bit fraction
// - one sampling tick per divisor clock cycles
// - sixteen-x tick; sixteen ticks per transmitted bit
// - divisor and line control load only on line-control write
// - transmit and receive enables, both set after reset
// - disabling finishes current character first
// - two sixteen-entry FIFOs, receive entries carry status
// - send frames back to back while FIFO holds data
// - busy until FIFO empty and last stop bit sent
// - falling line starts count; eighth tick confirms start
// - data sampled every sixteenth tick, then parity
// - low stop sample is framing error; store character
// - 5-8 bits, parity kinds, 1-2 stops, breaks
// - selectable depth including one-entry holding register
// - trigger levels one eighth to seven eighths
// - FIFOs one entry deep until FIFO enable set
// - data read gives 12 bits; write pushes byte
package astc_pkg;

    localparam logic [9:0] IDX_DATA = 10'h000;
    localparam logic [9:0] IDX_RSR  = 10'h001;
    localparam logic [9:0] IDX_FLAG = 10'h006;
    localparam logic [9:0] IDX_IBRD = 10'h009;
    localparam logic [9:0] IDX_FBRD = 10'h00A;
    localparam logic [9:0] IDX_LCRH = 10'h00B;
    localparam logic [9:0] IDX_CTL  = 10'h00C;
    localparam logic [9:0] IDX_IFLS = 10'h00D;

    localparam int CTL_EN  = 0;
    localparam int CTL_LBE = 7;
    localparam int CTL_TXE = 8;
    localparam int CTL_RXE = 9;
    localparam logic [9:0] CTL_RST  = 10'h300;
    localparam logic [5:0] IFLS_RST = 6'h12;

    localparam logic [3:0]  TICK_LAST  = 4'hF;   // sixteen ticks per bit
    localparam logic [3:0]  START_MID  = 4'h7;   // eighth tick of start bit
    localparam logic [22:0] BAUD_UNIT  = 23'h40; // one clock in 1/64 units

    typedef struct packed {
        logic       stick;
        logic [1:0] wlen;
        logic       fifo_enable_bit;
        logic       stp2;
        logic       eps;
        logic       pen;
        logic       brk;
    } astc_lcr_t;

    typedef struct packed {
        logic       oe;
        logic       be;
        logic       pe;
        logic       fe;
        logic [7:0] data;
    } astc_rxent_t;

    typedef struct packed {
        logic [15:0] div_int;
        logic [5:0]  div_frac;
        astc_lcr_t   lcr;
    } astc_work_t;

    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} astc_tx_t;
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} astc_rx_t;

    // trigger level code to entry count
    function automatic logic [4:0] astc_level(input logic [2:0] code);
        case (code)
            3'h0:    return 5'h02;
            3'h1:    return 5'h04;
            3'h2:    return 5'h08;
            3'h3:    return 5'h0C;
            default: return 5'h0E;
        endcase
    endfunction

endpackage

// ### hdl/astc_fifo.sv
// Purpose: byte or status FIFO with registered head data
// Assumes: pop only acts when not empty, push only when not full
// Notes:   one_entry_i caps the depth at one entry
module astc_fifo
    import astc_pkg::*;
#(
    parameter int W  = 8,
    parameter int AW = 4
) (
    input  wire logic         clk_i,
    input  wire logic         srst_i,
    input  wire logic         push_i,
    input  wire logic [W-1:0] wdata_i,
    input  wire logic         pop_i,
    input  wire logic         one_entry_i,
    output logic      [W-1:0] rdata_o,
    output logic              empty_o,
    output logic              full_o,
    output logic      [AW:0]  count_o
);
    logic [W-1:0]  mem_q [2**AW];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [AW-1:0] rp_n;
    logic [AW:0]   cnt_q;
    logic          do_push;
    logic          do_pop;

    assign empty_o = (cnt_q == '0);
    assign full_o  = one_entry_i ? !empty_o : cnt_q[AW];
    assign do_push = push_i && !full_o;
    assign do_pop  = pop_i && !empty_o;
    assign rp_n    = rp_q + AW'(do_pop);
    assign count_o = cnt_q;

    // storage has no reset on purpose
    always_ff @(posedge clk_i) begin
        if (do_push) begin
            mem_q[wp_q] <= wdata_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end else begin
            wp_q  <= wp_q + AW'(do_push);
            rp_q  <= rp_n;
            cnt_q <= cnt_q + (AW+1)'(do_push) - (AW+1)'(do_pop);
        end
    end

    // head register; bypass covers a write into the next head slot
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rdata_o <= '0;
        end else begin
            rdata_o <= (do_push && wp_q == rp_n) ? wdata_i : mem_q[rp_n];
        end
    end
endmodule

// ### hdl/astc_baud.sv
// Purpose: fractional sixteen-x tick generator
// Assumes: divisor in 1/64 units, zero stops the tick
// Notes:   tick spacing jitters by one clock to hit the mean exactly
module astc_baud
    import astc_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        srst_i,
    input  wire logic [21:0] div_i,
    output logic             tick_o
);
    logic [22:0] acc_q;
    logic [22:0] sum;

    assign sum = acc_q + BAUD_UNIT;

    // add one clock per cycle, emit a tick each time a divisor fits
    always_ff @(posedge clk_i) begin
        if (srst_i || div_i == '0) begin
            acc_q  <= '0;
            tick_o <= 1'b0;
        end else if (sum >= {1'b0, div_i}) begin
            acc_q  <= sum - {1'b0, div_i};
            tick_o <= 1'b1;
        end else begin
            acc_q  <= sum;
            tick_o <= 1'b0;
        end
    end
endmodule

// ### hdl/astc_core.sv
// Purpose: async serial transceiver with AHB-Lite register slave
// Assumes: single word transfers, rx_i asynchronous to clk_i
// Notes:   every access takes one wait state; response always OKAY
module astc_core
    import astc_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        srst_i,
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic      [31:0] hrdata_o,
    output logic             hreadyout_o,
    output logic             hresp_o,
    input  wire logic        rx_i,
    output logic             tx_o
);
    // bus state
    logic        pend_q;
    logic        wr_q;
    logic [9:0]  idx_q;
    logic        acc_req;
    logic        wr_stb;
    logic        rd_stb;
    logic [31:0] rdata_d;

    // software registers
    logic        en_q;
    logic        lbe_q;
    logic        txe_q;
    logic        rxe_q;
    logic [15:0] ibrd_q;
    logic [5:0]  fbrd_q;
    logic [5:0]  ifls_q;
    astc_work_t  work_q;
    logic [4:0]  rsr_q;

    // fifos and tick
    logic        tick;
    logic        tx_push;
    logic        tx_pop;
    logic [7:0]  tx_head;
    logic        tx_empty;
    logic        tx_full;
    logic [4:0]  tx_cnt;
    logic        rx_push;
    logic        rx_pop;
    astc_rxent_t rx_ent;
    logic [11:0] rx_head;
    logic        rx_empty;
    logic        rx_full;
    logic [4:0]  rx_cnt;

    // transmitter
    astc_tx_t    tx_st_q;
    logic [3:0]  tx_tk_q;
    logic [2:0]  tx_bit_q;
    logic [7:0]  tx_sh_q;
    logic        tx_par_q;
    logic        tx_stp2_q;
    logic        tx_line_q;
    logic        tx_bit_end;

    // receiver
    logic        rx_s1_q;
    logic        rx_s2_q;
    logic        rx_s3_q;
    logic        rx_lvl_q;
    logic        rx_ln;
    logic        rx_prev_q;
    astc_rx_t    rx_st_q;
    logic [3:0]  rx_tk_q;
    logic [2:0]  rx_bit_q;
    logic [7:0]  rx_dat_q;
    logic        rx_pe_q;
    logic        rx_zero_q;
    logic        rx_oe_q;
    logic        rx_end;
    logic        rx_false;

    assign acc_req = hsel_i && htrans_i[1] && hready_i;
    assign wr_stb  = pend_q && wr_q;
    assign rd_stb  = pend_q && !wr_q;

    // parity bit for the programmed length and kind
    function automatic logic par_of(input logic [7:0] d, input astc_lcr_t c);
        logic [7:0] m;
        m = d & (8'hFF >> (2'h3 - c.wlen));
        if (c.stick) begin
            return !c.eps;
        end
        return c.eps ? ^m : ~^m;
    endfunction

    // address phase capture; hsize ignored, only words are used
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            pend_q <= 1'b0;
            wr_q   <= 1'b0;
            idx_q  <= '0;
        end else begin
            pend_q <= acc_req;
            if (acc_req) begin
                wr_q  <= hwrite_i;
                idx_q <= haddr_i[11:2];
            end
        end
    end

    // one wait state so read data can come from a flop
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            hreadyout_o <= 1'b1;
            hresp_o     <= 1'b0;
        end else begin
            hresp_o <= 1'b0;
            if (acc_req) begin
                hreadyout_o <= 1'b0;
            end else if (pend_q) begin
                hreadyout_o <= 1'b1;
            end
        end
    end

    // read mux; unmapped words read zero
    always_comb begin
        rdata_d = '0;
        unique case (idx_q)
            IDX_DATA: rdata_d[11:0] = rx_head;
            IDX_RSR:  rdata_d[4:0]  = rsr_q;
            IDX_FLAG: rdata_d[9:0]  = {rx_cnt >= astc_level(ifls_q[5:3]),
                                       tx_cnt <= astc_level(ifls_q[2:0]),
                                       tx_empty, rx_full, tx_full, rx_empty,
                                       !tx_empty || tx_st_q != TX_IDLE,
                                       3'h0};
            IDX_IBRD: rdata_d[15:0] = ibrd_q;
            IDX_FBRD: rdata_d[5:0]  = fbrd_q;
            IDX_LCRH: rdata_d[7:0]  = work_q.lcr;
            IDX_CTL:  rdata_d[9:0]  = {rxe_q, txe_q, lbe_q, 6'h00, en_q};
            IDX_IFLS: rdata_d[5:0]  = ifls_q;
            default:  rdata_d       = '0;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            hrdata_o <= '0;
        end else if (rd_stb) begin
            hrdata_o <= rdata_d;
        end
    end

    // control register; both direction enables set out of reset, module enable clear
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            en_q  <= CTL_RST[CTL_EN];
            lbe_q <= CTL_RST[CTL_LBE];
            txe_q <= CTL_RST[CTL_TXE];
            rxe_q <= CTL_RST[CTL_RXE];
        end else if (wr_stb && idx_q == IDX_CTL) begin
            en_q  <= hwdata_i[CTL_EN];
            lbe_q <= hwdata_i[CTL_LBE];
            txe_q <= hwdata_i[CTL_TXE];
            rxe_q <= hwdata_i[CTL_RXE];
        end
    end

    // divisor staging and trigger levels
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            ibrd_q <= '0;
            fbrd_q <= '0;
            ifls_q <= IFLS_RST;
        end else if (wr_stb) begin
            if (idx_q == IDX_IBRD) begin
                ibrd_q <= hwdata_i[15:0];
            end
            if (idx_q == IDX_FBRD) begin
                fbrd_q <= hwdata_i[5:0];
            end
            if (idx_q == IDX_IFLS) begin
                ifls_q <= hwdata_i[5:0];
            end
        end
    end

    // working register only moves on a line-control write
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            work_q <= '0;
        end else if (wr_stb && idx_q == IDX_LCRH) begin
            work_q <= {ibrd_q, fbrd_q, hwdata_i[7:0]};
        end
    end

    // receive status; a new error wins over a same-cycle clear
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rsr_q <= '0;
        end else begin
            rsr_q <= ((wr_stb && idx_q == IDX_RSR) ? 5'h00 : rsr_q)
                   | {rx_false, {4{rx_end}} & {rx_full, rx_zero_q && !rx_ln, rx_pe_q, !rx_ln}};
        end
    end

    astc_baud u_baud (
        .clk_i  (clk_i),
        .srst_i (srst_i),
        .div_i  ({work_q.div_int, work_q.div_frac}),
        .tick_o (tick)
    );

    // a write while full is dropped
    assign tx_push = wr_stb && idx_q == IDX_DATA;
    assign rx_pop  = rd_stb && idx_q == IDX_DATA;

    astc_fifo #(
        .W  (8),
        .AW (4)
    ) u_txf (
        .clk_i       (clk_i),
        .srst_i      (srst_i),
        .push_i      (tx_push),
        .wdata_i     (hwdata_i[7:0]),
        .pop_i       (tx_pop),
        .one_entry_i (!work_q.lcr.fifo_enable_bit),
        .rdata_o     (tx_head),
        .empty_o     (tx_empty),
        .full_o      (tx_full),
        .count_o     (tx_cnt)
    );

    astc_fifo #(
        .W  (12),
        .AW (4)
    ) u_rxf (
        .clk_i       (clk_i),
        .srst_i      (srst_i),
        .push_i      (rx_push),
        .wdata_i     (rx_ent),
        .pop_i       (rx_pop),
        .one_entry_i (!work_q.lcr.fifo_enable_bit),
        .rdata_o     (rx_head),
        .empty_o     (rx_empty),
        .full_o      (rx_full),
        .count_o     (rx_cnt)
    );

    // frames start on a tick, so a stopped generator never leaves the line low
    assign tx_pop     = tx_st_q == TX_IDLE && en_q && txe_q && !tx_empty && tick;
    assign tx_bit_end = tick && tx_tk_q == TICK_LAST;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            tx_st_q   <= TX_IDLE;
            tx_tk_q   <= '0;
            tx_bit_q  <= '0;
            tx_sh_q   <= '0;
            tx_par_q  <= 1'b0;
            tx_stp2_q <= 1'b0;
            tx_line_q <= 1'b1;
        end else begin
            if (tick) begin
                tx_tk_q <= tx_tk_q + 4'h1;
            end
            unique case (tx_st_q)
                TX_IDLE: begin
                    tx_line_q <= 1'b1;
                    if (tx_pop) begin
                        tx_st_q   <= TX_START;
                        tx_tk_q   <= '0;
                        tx_sh_q   <= tx_head;
                        tx_par_q  <= par_of(tx_head, work_q.lcr);
                        tx_line_q <= 1'b0;
                    end
                end
                TX_START: begin
                    if (tx_bit_end) begin
                        tx_st_q   <= TX_DATA;
                        tx_bit_q  <= '0;
                        tx_line_q <= tx_sh_q[0];
                    end
                end
                TX_DATA: begin
                    if (tx_bit_end && tx_bit_q == {1'b1, work_q.lcr.wlen}) begin
                        tx_st_q   <= work_q.lcr.pen ? TX_PAR : TX_STOP;
                        tx_line_q <= work_q.lcr.pen ? tx_par_q : 1'b1;
                        tx_stp2_q <= work_q.lcr.stp2;
                    end else if (tx_bit_end) begin
                        tx_bit_q  <= tx_bit_q + 3'h1;
                        tx_sh_q   <= {1'b0, tx_sh_q[7:1]};
                        tx_line_q <= tx_sh_q[1];
                    end
                end
                TX_PAR: begin
                    if (tx_bit_end) begin
                        tx_st_q   <= TX_STOP;
                        tx_line_q <= 1'b1;
                        tx_stp2_q <= work_q.lcr.stp2;
                    end
                end
                TX_STOP: begin
                    if (tx_bit_end && tx_stp2_q) begin
                        tx_stp2_q <= 1'b0;
                    end else if (tx_bit_end) begin
                        tx_st_q <= TX_IDLE;
                    end
                end
            endcase
        end
    end

    // break forces the line low
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            tx_o <= 1'b1;
        end else begin
            tx_o <= work_q.lcr.brk ? 1'b0 : tx_line_q;
        end
    end

    // pin synchroniser; level moves only when stages two and three agree
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rx_s1_q  <= 1'b1;
            rx_s2_q  <= 1'b1;
            rx_s3_q  <= 1'b1;
            rx_lvl_q <= 1'b1;
        end else begin
            rx_s1_q <= rx_i;
            rx_s2_q <= rx_s1_q;
            rx_s3_q <= rx_s2_q;
            if (rx_s2_q == rx_s3_q) begin
                rx_lvl_q <= rx_s3_q;
            end
        end
    end

    // loopback feeds our own line back in
    assign rx_ln    = lbe_q ? tx_o : rx_lvl_q;
    assign rx_end   = rx_st_q == RX_STOP && tick && rx_tk_q == TICK_LAST;
    assign rx_false = rx_st_q == RX_START && tick && rx_tk_q == START_MID && rx_ln;
    assign rx_push  = rx_end && !rx_full;
    assign rx_ent   = '{oe: rx_oe_q, be: rx_zero_q && !rx_ln, pe: rx_pe_q,
                        fe: !rx_ln, data: rx_dat_q};

    // a lost character marks the next stored one with overrun
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rx_oe_q <= 1'b0;
        end else if (rx_end) begin
            rx_oe_q <= rx_full;
        end
    end

    // receiver; disable only blocks the next start
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rx_st_q   <= RX_IDLE;
            rx_prev_q <= 1'b1;
            rx_tk_q   <= '0;
            rx_bit_q  <= '0;
            rx_dat_q  <= '0;
            rx_pe_q   <= 1'b0;
            rx_zero_q <= 1'b0;
        end else begin
            rx_prev_q <= rx_ln;
            if (tick) begin
                rx_tk_q <= rx_tk_q + 4'h1;
            end
            unique case (rx_st_q)
                RX_IDLE: begin
                    if (en_q && rxe_q && rx_prev_q && !rx_ln) begin
                        rx_st_q <= RX_START;
                        rx_tk_q <= '0;
                    end
                end
                RX_START: begin
                    if (rx_false) begin
                        rx_st_q <= RX_IDLE;
                    end else if (tick && rx_tk_q == START_MID) begin
                        rx_st_q   <= RX_DATA;
                        rx_tk_q   <= '0;
                        rx_bit_q  <= '0;
                        rx_dat_q  <= '0;
                        rx_pe_q   <= 1'b0;
                        rx_zero_q <= 1'b1;
                    end
                end
                RX_DATA: begin
                    if (tick && rx_tk_q == TICK_LAST) begin
                        rx_dat_q[rx_bit_q] <= rx_ln;
                        rx_zero_q <= rx_zero_q && !rx_ln;
                        rx_bit_q  <= rx_bit_q + 3'h1;
                        if (rx_bit_q == {1'b1, work_q.lcr.wlen}) begin
                            rx_st_q <= work_q.lcr.pen ? RX_PAR : RX_STOP;
                        end
                    end
                end
                RX_PAR: begin
                    if (tick && rx_tk_q == TICK_LAST) begin
                        rx_pe_q   <= rx_ln != par_of(rx_dat_q, work_q.lcr);
                        rx_zero_q <= rx_zero_q && !rx_ln;
                        rx_st_q   <= RX_STOP;
                    end
                end
                RX_STOP: begin
                    if (rx_end) begin
                        rx_st_q <= RX_IDLE;
                    end
                end
            endcase
        end
    end
endmodule

// ### bench/astc_core_props.sv
// Purpose: bus and line timing checks beside astc_core
// Assumes: one clock, synchronous active-high reset
// Notes:   ticks come at most once a clock, so a bit lasts sixteen clocks or more
module astc_core_props
    import astc_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        srst_i,
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    input  wire logic [31:0] hrdata_o,
    input  wire logic        hreadyout_o,
    input  wire logic        hresp_o,
    input  wire logic        rx_i,
    input  wire logic        tx_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);

    // transfer taken by the slave, and one that sets the break bit
    sequence take_s;
        hsel_i && htrans_i[1] && hready_i;
    endsequence
    sequence brk_s;
        (hsel_i && htrans_i[1] && hready_i && hwrite_i && haddr_i[11:2] == IDX_LCRH)
            ##1 hwdata_i[0];
    endsequence

    chk_okay_only: assert property (!hresp_o) else $error("error response");
    chk_one_wait: assert property (take_s |=> !hreadyout_o ##1 hreadyout_o)
        else $error("wait state count wrong");
    chk_rdata_hold: assert property (hreadyout_o |=> $stable(hrdata_o))
        else $error("read data moved early");
    chk_write_keeps: assert property (take_s ##0 hwrite_i |-> ##2 $stable(hrdata_o))
        else $error("write changed read data");
    chk_unmapped_zero: assert property (take_s ##0 (!hwrite_i && haddr_i[11:2] > IDX_IFLS)
        |-> ##2 hrdata_o == 32'h0) else $error("unmapped read not zero");
    chk_start_len: assert property ($fell(tx_o) |-> (!tx_o) [*8] ##1 (!tx_o) [*8])
        else $error("start bit too short");
    chk_break_low: assert property (brk_s |-> ##[1:2] !tx_o)
        else $error("break not driven");
    chk_reset_idle: assert property ($fell(srst_i) |-> tx_o && hreadyout_o)
        else $error("not idle after reset");
endmodule

bind astc_core astc_core_props u_props (.clk_i(clk_i), .srst_i(srst_i), .hsel_i(hsel_i),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i),
    .hwdata_i(hwdata_i), .hready_i(hready_i), .hrdata_o(hrdata_o),
    .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .rx_i(rx_i), .tx_o(tx_o));

// ### bench/astc_peer.sv
// Purpose: remote serial transceiver facing astc_core
// Assumes: one bit lasts BIT clocks of clk_i
// Notes:   the line idles high between frames, as the link does
module astc_peer #(
    parameter int BIT = 16
) (
    input  wire logic clk_i,
    input  wire logic line_i,
    output logic      line_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [9:0] frame;
    int         frames = 0;
    initial line_o = 1'b1;
    // start, data, parity, stop sampled mid bit
    always begin
        @(negedge line_i);
        repeat (BIT / 2) @(posedge clk_i);
        for (int i = 0; i < 10; i++) begin
            frame[i] = line_i;
            if (i < 9) repeat (BIT) @(posedge clk_i);
        end
        frames++;
    end
    task automatic send(input logic [9:0] bits);
        for (int i = 0; i < 10; i++) begin
            line_o <= bits[i];
            repeat (BIT) @(posedge clk_i);
        end
        line_o <= 1'b1;
        repeat (BIT) @(posedge clk_i); // idle bit so the next start has a falling edge
    endtask
    // low for a quarter bit only: not a real start
    task automatic glitch();
        line_o <= 1'b0;
        repeat (BIT / 4) @(posedge clk_i);
        line_o <= 1'b1;
        repeat (BIT * 2) @(posedge clk_i);
    endtask
endmodule

// ### bench/testbench.sv
// Purpose: register-level regression of astc_core with a remote peer
// Assumes: divisor 1.0 gives a tick each clock, one bit is 16 clocks
// Notes:   expected frames are built from the frame layout
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import astc_pkg::*;
    logic        clk_i = 1'b0;
    logic        srst_i = 1'b1;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic        hready;
    logic        hresp;
    logic        rx;
    logic        tx;
    logic [31:0] rd;
    logic [7:0]  lc [4] = '{8'h56, 8'h52, 8'hD2, 8'hD6};
    int          miscompares = 0;
    int          checked = 0;
    int          n0;
    always #2.5 clk_i = ~clk_i;
    astc_core u_dut (.clk_i(clk_i), .srst_i(srst_i), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
        .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
        .rx_i(rx), .tx_o(tx));
    astc_peer u_peer (.clk_i(clk_i), .line_i(tx), .line_o(rx));
    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // bounded wait for a signal; running out ends the run
    task automatic await(ref logic ok, input int lim);
        int n;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ok !== 1'b1 && n < lim);
        if (ok !== 1'b1) begin
            miscompares++;
            tally_and_finish();
        end
    endtask
    task automatic bus(input logic [9:0] idx, input logic wr, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {20'h0, idx, 2'h0};
        hwrite <= wr;
        await(hready, 64);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        await(hready, 64);
        rd = hrdata;
    endtask
    task automatic wr(input logic [9:0] idx, input logic [31:0] wd);
        bus(idx, 1'b1, wd);
    endtask
    task automatic rdc(input logic [9:0] idx, input logic [31:0] exp);
        bus(idx, 1'b0, 32'h0);
        cmp(rd, exp);
    endtask
    // reprogram only while the module is off
    task automatic cfg(input logic [7:0] v);
        wr(IDX_CTL, 32'h300);
        wr(IDX_LCRH, {24'h0, v});
        wr(IDX_CTL, 32'h301);
    endtask
    // frame count plus a margin past the stop bit
    task automatic wait_frames(input int target);
        logic got;
        for (int n = 0; n < 4000 && u_peer.frames < target; n++) @(posedge clk_i);
        got = u_peer.frames >= target;
        cmp({31'h0, got}, 32'h1);
        if (!got) tally_and_finish();
        repeat (16) @(posedge clk_i);
    endtask
    initial begin
        logic [6:0] d7;
        logic       par;
        repeat (12) @(posedge clk_i);
        srst_i <= 1'b0;
        @(posedge clk_i);
        rdc(IDX_CTL, 32'h300);
        rdc(IDX_FLAG, 32'h190);
        rdc(IDX_IFLS, 32'h12);
        rdc(10'h3FF, 32'h0);
        // staged divisor alone leaves the line idle
        wr(IDX_IBRD, 32'h1);
        wr(IDX_CTL, 32'h301);
        wr(IDX_DATA, 32'h5A);
        repeat (64) @(posedge clk_i);
        cmp({31'h0, tx}, 32'h1);
        bus(IDX_FLAG, 1'b0, 32'h0);
        cmp(rd & 32'hF8, 32'h38);
        cfg(8'h60);
        wait_frames(1);
        cmp({22'h0, u_peer.frame}, {22'h0, 1'b1, 8'h5A, 1'b0});
        bus(IDX_FLAG, 1'b0, 32'h0);
        cmp(rd & 32'h8, 32'h0);
        // every parity kind on seven-bit characters
        foreach (lc[i]) begin
            cfg(lc[i]);
            d7 = 7'h35 + 7'(i);
            par = lc[i][7] ? ~lc[i][2] : (lc[i][2] ? ^d7 : ~^d7);
            n0 = u_peer.frames;
            wr(IDX_DATA, {25'h0, d7});
            wait_frames(n0 + 1);
            cmp({22'h0, u_peer.frame}, {22'h0, 1'b1, par, d7, 1'b0});
        end
        // disable mid frame: first character ends, second waits
        cfg(8'h70);
        n0 = u_peer.frames;
        wr(IDX_DATA, 32'hC3);
        wr(IDX_DATA, 32'h3C);
        wr(IDX_CTL, 32'h300);
        wait_frames(n0 + 1);
        repeat (200) @(posedge clk_i);
        cmp(32'(u_peer.frames), 32'(n0 + 1));
        cmp({22'h0, u_peer.frame}, {22'h0, 1'b1, 8'hC3, 1'b0});
        bus(IDX_FLAG, 1'b0, 32'h0);
        cmp(rd & 32'h8, 32'h8);
        wr(IDX_CTL, 32'h301);
        wait_frames(n0 + 2);
        cmp({22'h0, u_peer.frame}, {22'h0, 1'b1, 8'h3C, 1'b0});
        cfg(8'h71);
        repeat (20) @(posedge clk_i);
        cmp({31'h0, tx}, 32'h0);
        cfg(8'h70);
        // receive: clean, bad stop, break, false start
        u_peer.send({1'b1, 8'hA5, 1'b0});
        u_peer.send({1'b0, 8'h3C, 1'b0});
        u_peer.send(10'h0);
        rdc(IDX_DATA, 32'h0A5);
        rdc(IDX_DATA, 32'h13C);
        rdc(IDX_DATA, 32'h500);
        wr(IDX_RSR, 32'h0);
        u_peer.glitch();
        rdc(IDX_RSR, 32'h10);
        // one-entry mode overruns on the second character
        cfg(8'h60);
        wr(IDX_RSR, 32'h0);
        u_peer.send({1'b1, 8'h11, 1'b0});
        u_peer.send({1'b1, 8'h22, 1'b0});
        rdc(IDX_RSR, 32'h8);
        rdc(IDX_DATA, 32'h011);
        u_peer.send({1'b1, 8'h33, 1'b0});
        rdc(IDX_DATA, 32'h833);
        tally_and_finish();
    end
endmodule
